// ===== core/srsg_pkg.sv
package srsg_pkg;
  // Clock rate and derived second tick
  localparam int CLK_HZ = 40000000;
  localparam int SEC_CYCLES = CLK_HZ;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_REV_WAIT = 8'h04;
  localparam logic [7:0] REG_REV_THR = 8'h08;
  localparam logic [7:0] REG_LR_IDLE = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_COUNTS = 8'h14;
  localparam logic [7:0] REG_IRQ_STAT = 8'h18;
  localparam logic [7:0] REG_IRQ_MASK = 8'h1c;
  localparam logic [7:0] REG_PEAK = 8'h20;
  // Limits and defaults
  localparam logic [8:0] WAIT_MIN_S = 9'h01e;
  localparam logic [8:0] WAIT_MAX_S = 9'h12c;
  localparam logic [8:0] REV_WAIT_RST = 9'h01e;
  localparam logic [8:0] LR_IDLE_RST = 9'h023;
  localparam logic [6:0] THR_MIN = 7'h01;
  localparam logic [6:0] THR_MAX = 7'h64;
  localparam logic [6:0] THR_RST = 7'h23;
  localparam logic [1:0] REV_TRIP_CNT = 2'h2;
  localparam logic [3:0] LR_TRIP_CNT = 4'ha;
  localparam logic [6:0] LR_SPEED_PCT = 7'h14;
  localparam logic [6:0] FULL_PCT = 7'h64;
  // Filter shift: time constant 2^k cycles, far below a start's torque period
  localparam int FILT_SHIFT = 4;
  // Interrupt bit positions
  localparam int IRQ_REV_EVT = 0;
  localparam int IRQ_REV_TRIP = 1;
  localparam int IRQ_LR_FAIL = 2;
  localparam int IRQ_LR_TRIP = 3;
  localparam int IRQ_BASE_TRIP = 4;
  localparam int IRQ_W = 5;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RAMP = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b011,
    ST_HALT = 3'b100
  } srsg_state_type;
endpackage : srsg_pkg

// ===== core/srsg_guard.sv
// How it works
// - Count reverse events 0..2; trip when the second one is seen.
// - Wait a 30..300 s interval, default 30 s, between reverse-check attempts.
// - Reverse threshold settable 1..100 percent of load demand, default 35.
// - Reverse check runs on every start until the first good start after power-up.
// - Load demand is low-pass filtered before any evaluation.
// - Hold filtered peak during ramp; peak below threshold means reversed motor.
// - Peak tracking starts only once estimated speed first goes positive.
// - At ramp end, speed under 20 percent of target is a locked rotor.
// - Locked-rotor warning flag is high while detection is active.
// - After locked-rotor failure, idle 30..300 s, default 35 s, then restart.
// - Count locked-rotor failed starts from 0 to 10.
// - Ten consecutive failures disable the drive, trip, enter halt state.
// - After exhausting retries no restart happens until a power cycle.
// - Base phasing trips latch until a power cycle.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module srsg_guard
  import srsg_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Motor loop
  input wire logic start_req_in,
  input wire logic ramp_end_in,
  input wire logic [6:0] load_pct_in,
  input wire logic signed [15:0] speed_est_in,
  input wire logic [15:0] speed_tgt_in,
  input wire logic base_trip_in,
  // Control and status
  output logic run_en_out,
  output logic lr_warn_out,
  output logic rev_trip_out,
  output logic lr_trip_out,
  output logic base_trip_out,
  output logic irq_out
);
  srsg_state_type state_ff;
  logic [8:0] rev_wait_ff;
  logic [6:0] rev_thr_ff;
  logic [8:0] lr_idle_ff;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic [1:0] rev_cnt_ff;
  logic [3:0] lr_cnt_ff;
  logic rev_armed_ff;
  logic rev_trip_ff;
  logic lr_trip_ff;
  logic base_trip_ff;
  logic tracking_ff;
  logic [10:0] filt_ff;
  logic [6:0] peak_ff;
  logic [25:0] tick_ff;
  logic [8:0] secs_ff;
  logic [31:0] prdata_ff;
  logic wr_en;
  logic rd_en;
  logic sec_tick;
  logic [6:0] filt_pct;
  logic rev_evt;
  logic lr_fail;
  logic good_start;
  logic [IRQ_W-1:0] evt_vec;
  logic [8:0] wait_target_ff;
  logic base_hit;

  // Clamp a programmed wait into its legal seconds range
  function automatic logic [8:0] clamp_wait(input logic [31:0] v);
    if (v[31:0] < {23'h000000, WAIT_MIN_S}) begin
      return WAIT_MIN_S;
    end else if (v[31:0] > {23'h000000, WAIT_MAX_S}) begin
      return WAIT_MAX_S;
    end else begin
      return v[8:0];
    end
  endfunction : clamp_wait

  // Zero-wait APB; writes land in the access cycle
  assign wr_en = psel_in & penable_in & pwrite_in;
  assign rd_en = psel_in & ~pwrite_in;
  assign pready_out = 1'b1;
  assign pslverr_out = 1'b0;
  assign prdata_out = prdata_ff;

  // Configuration registers with range clamps
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      rev_wait_ff <= REV_WAIT_RST;
      rev_thr_ff <= THR_RST;
      lr_idle_ff <= LR_IDLE_RST;
      irq_mask_ff <= '0;
    end else if (wr_en) begin
      if (paddr_in == REG_REV_WAIT) begin
        rev_wait_ff <= clamp_wait(pwdata_in);
      end else if (paddr_in == REG_REV_THR) begin
        if (pwdata_in[6:0] < THR_MIN || pwdata_in[31:7] != '0) begin
          rev_thr_ff <= (pwdata_in[31:7] != '0) ? THR_MAX : THR_MIN;
        end else if (pwdata_in[6:0] > THR_MAX) begin
          rev_thr_ff <= THR_MAX;
        end else begin
          rev_thr_ff <= pwdata_in[6:0];
        end
      end else if (paddr_in == REG_LR_IDLE) begin
        lr_idle_ff <= clamp_wait(pwdata_in);
      end else if (paddr_in == REG_IRQ_MASK) begin
        irq_mask_ff <= pwdata_in[IRQ_W-1:0];
      end
    end
  end

  // Read mux, registered at setup so data is valid in the access cycle
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      prdata_ff <= '0;
    end else if (rd_en && !penable_in) begin
      if (paddr_in == REG_CTRL) begin
        prdata_ff <= {29'h0, state_ff};
      end else if (paddr_in == REG_REV_WAIT) begin
        prdata_ff <= {23'h0, rev_wait_ff};
      end else if (paddr_in == REG_REV_THR) begin
        prdata_ff <= {25'h0, rev_thr_ff};
      end else if (paddr_in == REG_LR_IDLE) begin
        prdata_ff <= {23'h0, lr_idle_ff};
      end else if (paddr_in == REG_STATUS) begin
        prdata_ff <= {26'h0, rev_armed_ff, lr_warn_out, base_trip_ff, lr_trip_ff,
                      rev_trip_ff, run_en_out};
      end else if (paddr_in == REG_COUNTS) begin
        prdata_ff <= {20'h0, lr_cnt_ff, 6'h0, rev_cnt_ff};
      end else if (paddr_in == REG_IRQ_STAT) begin
        prdata_ff <= {27'h0, irq_stat_ff};
      end else if (paddr_in == REG_IRQ_MASK) begin
        prdata_ff <= {27'h0, irq_mask_ff};
      end else if (paddr_in == REG_PEAK) begin
        prdata_ff <= {25'h0, peak_ff};
      end else begin
        prdata_ff <= '0; // Unmapped reads as zero
      end
    end
  end

  // First-order IIR; the shift keeps the time constant short
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      filt_ff <= '0;
    end else begin
      filt_ff <= filt_ff - (filt_ff >> FILT_SHIFT) + {4'h0, load_pct_in};
    end
  end
  assign filt_pct = filt_ff[10:4];

  // Peak hold gated by first positive speed
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      tracking_ff <= 1'b0;
      peak_ff <= '0;
    end else if (state_ff != ST_RAMP) begin
      tracking_ff <= 1'b0;
      peak_ff <= (state_ff == ST_IDLE && start_req_in) ? 7'h00 : peak_ff;
    end else begin
      if (speed_est_in > 16'sd0) begin
        tracking_ff <= 1'b1;
      end
      if (tracking_ff && filt_pct > peak_ff) begin
        peak_ff <= filt_pct;
      end
    end
  end

  // Ramp-end decisions; speed*100 < target*20 avoids a divider
  assign lr_fail = (state_ff == ST_RAMP) && ramp_end_in &&
                   ({7'h0, speed_est_in[15] ? 16'h0000 : speed_est_in} * {16'h0, FULL_PCT} <
                    {7'h0, speed_tgt_in} * {16'h0, LR_SPEED_PCT});
  assign rev_evt = (state_ff == ST_RAMP) && ramp_end_in && !lr_fail &&
                   rev_armed_ff && (peak_ff < rev_thr_ff);
  assign good_start = (state_ff == ST_RAMP) && ramp_end_in && !lr_fail && !rev_evt;
  assign lr_warn_out = (state_ff == ST_RAMP);

  // One-second prescaler and seconds counter for waits
  assign sec_tick = (tick_ff == 26'(SEC_CYCLES - 1));
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in || state_ff != ST_WAIT) begin
      tick_ff <= '0;
      secs_ff <= '0;
    end else if (sec_tick) begin
      tick_ff <= '0;
      secs_ff <= secs_ff + 9'h001;
    end else begin
      tick_ff <= tick_ff + 26'h0000001;
    end
  end

  // Wait length latched by which failure led into the wait
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      wait_target_ff <= REV_WAIT_RST;
    end else if (rev_evt) begin
      wait_target_ff <= rev_wait_ff;
    end else if (lr_fail) begin
      wait_target_ff <= lr_idle_ff;
    end
  end

  // Halt on the trip edge itself, so the motor never runs a cycle while fault_halt_state
  assign base_hit = base_trip_in | base_trip_ff;

  // Start-up sequencer; halt exits only through reset (power cycle)
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (base_hit) begin
            state_ff <= ST_HALT;
          end else if (start_req_in) begin
            state_ff <= ST_RAMP;
          end
        end
        ST_RAMP: begin
          if (base_hit) begin
            state_ff <= ST_HALT;
          end else if (lr_fail) begin
            state_ff <= (lr_cnt_ff + 4'h1 >= LR_TRIP_CNT) ? ST_HALT : ST_WAIT;
          end else if (rev_evt) begin
            state_ff <= (rev_cnt_ff + 2'h1 >= REV_TRIP_CNT) ? ST_HALT : ST_WAIT;
          end else if (ramp_end_in) begin
            state_ff <= ST_RUN;
          end
        end
        ST_WAIT: begin
          if (base_hit) begin
            state_ff <= ST_HALT;
          end else if (sec_tick && secs_ff + 9'h001 >= wait_target_ff) begin
            state_ff <= ST_RAMP;
          end
        end
        ST_RUN: begin
          if (base_hit) begin
            state_ff <= ST_HALT;
          end else if (!start_req_in) begin
            state_ff <= ST_IDLE;
          end
        end
        ST_HALT: state_ff <= ST_HALT;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
  assign run_en_out = (state_ff == ST_RAMP) || (state_ff == ST_RUN);

  // Event counters and latched trips, cleared by reset; a good start also clears lr_cnt_ff and rev_armed_ff
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      rev_cnt_ff <= '0;
      lr_cnt_ff <= '0;
      rev_armed_ff <= 1'b1;
      rev_trip_ff <= 1'b0;
      lr_trip_ff <= 1'b0;
      base_trip_ff <= 1'b0;
    end else begin
      if (base_trip_in) begin
        base_trip_ff <= 1'b1;
      end
      if (rev_evt) begin
        rev_cnt_ff <= rev_cnt_ff + 2'h1;
        if (rev_cnt_ff + 2'h1 >= REV_TRIP_CNT) begin
          rev_trip_ff <= 1'b1;
        end
      end
      if (good_start) begin
        rev_armed_ff <= 1'b0;
        lr_cnt_ff <= '0;
      end
      if (lr_fail && lr_cnt_ff < LR_TRIP_CNT) begin
        lr_cnt_ff <= lr_cnt_ff + 4'h1;
        if (lr_cnt_ff + 4'h1 >= LR_TRIP_CNT) begin
          lr_trip_ff <= 1'b1;
        end
      end
    end
  end
  assign rev_trip_out = rev_trip_ff;
  assign lr_trip_out = lr_trip_ff;
  assign base_trip_out = base_trip_ff;

  // Sticky interrupt status; a new event beats a same-cycle clear
  assign evt_vec = {base_trip_in & ~base_trip_ff, lr_fail & (lr_cnt_ff == 4'h9),
                    lr_fail, rev_evt & (rev_cnt_ff == 2'h1), rev_evt};
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      irq_stat_ff <= '0;
    end else if (wr_en && paddr_in == REG_IRQ_STAT) begin
      irq_stat_ff <= (irq_stat_ff & ~pwdata_in[IRQ_W-1:0]) | evt_vec;
    end else begin
      irq_stat_ff <= irq_stat_ff | evt_vec;
    end
  end
  assign irq_out = |(irq_stat_ff & irq_mask_ff);
endmodule : srsg_guard
`default_nettype wire

// ===== verification/srsg_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module srsg_motor_model (
  // Clock and guard state
  input wire logic mclk_in,
  input wire logic ramp_in,
  // Scenario knobs
  input wire logic signed [15:0] spd_in,
  input wire logic [6:0] ld_pre_in,
  input wire logic [6:0] ld_in,
  // Motor loop outputs
  output logic ramp_end_out,
  output logic [6:0] load_out,
  output logic signed [15:0] speed_out
);
  localparam int SYNC = 40;
  localparam int RAMP = 200;
  logic [8:0] cnt_ff;
  // Ramp timer runs only while the guard ramps, so each ramp ends once
  always_ff @(posedge mclk_in) begin
    cnt_ff <= ramp_in ? cnt_ff + 9'h001 : 9'h000;
  end
  // Sync surge comes first, speed turns positive only later
  assign load_out = (cnt_ff < SYNC) ? ld_pre_in : ld_in;
  assign speed_out = !ramp_in ? 16'sh0 : (cnt_ff < 2 * SYNC) ? -16'sd5 : spd_in;
  assign ramp_end_out = ramp_in && cnt_ff == RAMP;
endmodule : srsg_motor_model
`default_nettype wire

// ===== verification/srsg_guard_props.sv
`timescale 1ns/1ps
`default_nettype none
module srsg_guard_props (
  // Watched ports
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic ramp_end_in,
  input wire logic base_trip_in,
  input wire logic signed [15:0] speed_est_in,
  input wire logic [15:0] speed_tgt_in,
  input wire logic run_en_out,
  input wire logic lr_warn_out,
  input wire logic rev_trip_out,
  input wire logic lr_trip_out,
  input wire logic base_trip_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  logic slow;
  logic [2:0] trips;
  // Speed under a fifth of target, widened so no product overflows
  assign slow = int'(speed_est_in) * 100 < int'(speed_tgt_in) * 20;
  assign trips = {rev_trip_out, lr_trip_out, base_trip_out};
  sequence s_end; lr_warn_out && ramp_end_in; endsequence
  sequence s_stall; s_end ##0 slow; endsequence
  property p_warn;
    lr_warn_out && !ramp_end_in && !base_trip_in |=> lr_warn_out && run_en_out;
  endproperty
  a_warn: assert property (p_warn) else $error("warn outside run");
  property p_lr; s_stall |=> !run_en_out && !lr_warn_out; endproperty
  a_lr: assert property (p_lr) else $error("stall not stopped");
  property p_idle; s_stall |=> !run_en_out [*8]; endproperty
  a_idle: assert property (p_idle) else $error("restart too soon");
  property p_base; base_trip_in |=> base_trip_out; endproperty
  a_base: assert property (p_base) else $error("base trip lost");
  property p_hold; 1'b1 |-> (trips & $past(trips)) == $past(trips); endproperty
  a_hold: assert property (p_hold) else $error("trip cleared");
  property p_halt; |trips |-> !run_en_out && !lr_warn_out; endproperty
  a_halt: assert property (p_halt) else $error("runs while fault_halt_state");
  property p_rev; $rose(rev_trip_out) |-> $past(lr_warn_out && ramp_end_in); endproperty
  a_rev: assert property (p_rev) else $error("reverse trip off ramp end");
  property p_ltr; $rose(lr_trip_out) |-> $past(lr_warn_out && ramp_end_in && slow); endproperty
  a_ltr: assert property (p_ltr) else $error("stall trip off ramp end");
endmodule : srsg_guard_props
bind srsg_guard srsg_guard_props u_props (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
  .ramp_end_in(ramp_end_in), .base_trip_in(base_trip_in), .speed_est_in(speed_est_in),
  .speed_tgt_in(speed_tgt_in), .run_en_out(run_en_out), .lr_warn_out(lr_warn_out),
  .rev_trip_out(rev_trip_out), .lr_trip_out(lr_trip_out), .base_trip_out(base_trip_out));
`default_nettype wire

// ===== verification/srsg_guard_tb.sv
`timescale 1ns/1ps
`default_nettype none
module srsg_guard_tb;
  import srsg_pkg::*;
  logic clk, rst_b, psel, pen, pwr, start, btrip, pready, rend, run, warn, bout, irq;
  logic slverr, rtrip, ltrip;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q[$];
  logic [6:0] load, ld_pre, ld;
  logic signed [15:0] spd, spd_fin;
  logic [15:0] tgt, rnd;
  int err_total, checks_done;
  srsg_guard uut (.mclk_in(clk), .rst_b_in(rst_b), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(slverr), .start_req_in(start), .ramp_end_in(rend),
    .load_pct_in(load), .speed_est_in(spd), .speed_tgt_in(tgt), .base_trip_in(btrip),
    .run_en_out(run), .lr_warn_out(warn), .rev_trip_out(rtrip), .lr_trip_out(ltrip),
    .base_trip_out(bout), .irq_out(irq));
  srsg_motor_model u_motor (.mclk_in(clk), .ramp_in(warn), .spd_in(spd_fin),
    .ld_pre_in(ld_pre), .ld_in(ld), .ramp_end_out(rend), .load_out(load), .speed_out(spd));
  // Clock at 40 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task tally_and_finish;
    if (err_total == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // Each completed read meets the oldest noted value
  always @(posedge clk) begin
    if (psel && pen && !pwr && pready === 1'b1) cmp(prdata, q.pop_front());
    if (psel && pen && pready === 1'b1) cmp({31'h0, slverr}, 32'h0);
  end
  // One APB transfer; an idle edge follows so psel is never driven twice at once
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) begin
      err_total++;
      tally_and_finish();
    end
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // Bounded wait for the ramp flag, sampled away from the active edge
  task wt(input logic lvl);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (warn !== lvl && n < 500);
    if (n >= 500) begin
      err_total++;
      tally_and_finish();
    end
    @(posedge clk);
  endtask : wt
  task go(input logic signed [15:0] sf, input logic [6:0] lp, input logic [6:0] l);
    spd_fin <= sf;
    ld_pre <= lp;
    ld <= l;
    start <= 1'b1;
    @(posedge clk);
    wt(1'b1);
    wt(1'b0);
  endtask : go
  task pcyc;
    start <= 1'b0;
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
  endtask : pcyc
  initial begin
    {psel, pen, pwr, start, btrip} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    tgt = 16'h03e8;
    {spd_fin, ld_pre, ld} = 30'h0;
    err_total = 0;
    checks_done = 0;
    rnd = 16'h87d3;
    pcyc();
    // Defaults and clamping of settings
    rd(REG_REV_WAIT, 32'h1e);
    rd(REG_LR_IDLE, 32'h23);
    rd(REG_COUNTS, 32'h0);
    rd(8'h40, 32'h0);
    rd(REG_REV_THR, 32'h23);
    apb(1'b1, REG_REV_THR, 32'h0);
    rd(REG_REV_THR, 32'h1);
    apb(1'b1, REG_REV_THR, 32'h7f);
    rd(REG_REV_THR, 32'h64);
    apb(1'b1, REG_REV_WAIT, 32'h1f4);
    rd(REG_REV_WAIT, 32'h12c);
    apb(1'b1, REG_LR_IDLE, 32'h0a);
    rd(REG_LR_IDLE, 32'h1e);
    apb(1'b1, REG_REV_THR, 32'h23);
    apb(1'b1, REG_IRQ_MASK, 32'h1f);
    // Stalled rotor: 150 of 1000 is under a fifth
    go(16'sd150, 7'h5a, 7'h5a);
    cmp({31'h0, irq}, 32'h1);
    rd(REG_CTRL, 32'h2);
    rd(REG_COUNTS, 32'h100);
    rd(REG_IRQ_STAT, 32'h4);
    rd(REG_STATUS, 32'h20);
    cmp({30'h0, rtrip, ltrip}, 32'h0);
    apb(1'b1, REG_IRQ_MASK, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    apb(1'b1, REG_IRQ_STAT, 32'h4);
    apb(1'b1, REG_IRQ_MASK, 32'h1f);
    cmp({31'h0, irq}, 32'h0);
    pcyc();
    rd(REG_COUNTS, 32'h0);
    // Surge only during sync, weak torque once turning forward
    go(16'sd900, 7'h5a, 7'h0a);
    rd(REG_CTRL, 32'h2);
    rd(REG_COUNTS, 32'h1);
    rd(REG_IRQ_STAT, 32'h1);
    rd(REG_STATUS, 32'h20);
    cmp({30'h0, rtrip, ltrip}, 32'h0);
    pcyc();
    // Healthy start with random load, then a second start skips the check
    rnd = lfsr(rnd);
    go(16'sd900, 7'h0a, 7'h28 + rnd[4:0]);
    rd(REG_CTRL, 32'h3);
    rd(REG_PEAK, {25'h0, 7'h28 + {2'h0, rnd[4:0]}});
    start <= 1'b0;
    repeat (3) @(posedge clk);
    rd(REG_CTRL, 32'h0);
    go(16'sd900, 7'h0a, 7'h0a);
    rd(REG_CTRL, 32'h3);
    rd(REG_STATUS, 32'h1);
    // Base trip latches through restart demands
    btrip <= 1'b1;
    @(posedge clk);
    btrip <= 1'b0;
    start <= 1'b0;
    repeat (3) @(posedge clk);
    start <= 1'b1;
    repeat (3) @(posedge clk);
    cmp({30'h0, bout, run}, 32'h2);
    rd(REG_CTRL, 32'h4);
    pcyc();
    cmp({31'h0, bout}, 32'h0);
    tally_and_finish();
  end
endmodule : srsg_guard_tb
`default_nettype wire
